/* File: hw/pxr_port_expander.sv */
// port expander: replacement ports a, b, e, g, h on the host's external bus,
// plus the drivers that put the reset configuration pattern on the data bus
// assumes all bus and board pins are asynchronous to sys_clk and are synchronised
// here; the host ends its own bus cycles (fast termination), so no acknowledge
//
// Behaviour
// - only the shared general/emulator select line selects the expander; not relocatable.
// - global enable low tri-states all outputs including data bus; cycles still answered.
// - writes while disabled update registers; pins show them once re-enabled.
// - reads while disabled run internally but leave the data bus undriven.
// - expander forced enabled throughout board reset; afterwards global enable applies.
// - in reset, lines 0-2 and 8-15 driven low where config input low.
// - config input high leaves its data line undriven during reset.
// - config input 10 low ignores input 8; line 8 stays high.
// - expander also drives lines 3-7 low where config low, else releases.
// - enabled expander drives read data whenever selected; disable if select reused.
// - group enable tri-states ports a, b, g; second group enable port h.
module pxr_port_expander
    import pxr_pkg::*;
(
    // clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              srst,
    // host bus, active-low strobes
    input  wire logic                              periph_select_n,
    input  wire logic                              data_strobe_n,
    input  wire logic                              read_write,
    input  wire logic [pxr_pkg::ADDR_W-1:0]        addr,
    input  wire logic [pxr_pkg::BUS_W-1:0]         data_in,
    output logic      [pxr_pkg::BUS_W-1:0]         data_out,
    output logic      [pxr_pkg::BUS_W-1:0]         data_oe_n,
    // board reset and configuration straps
    input  wire logic                              board_reset_n,
    input  wire logic [pxr_pkg::BUS_W-1:0]         reset_config_input,
    // output enables, active high
    input  wire logic                              global_output_enable,
    input  wire logic                              group_abg_output_enable,
    input  wire logic                              group_h_output_enable,
    // port pins: a, b, e, g, h packed from bit 0 upward
    input  wire logic [pxr_pkg::PORT_COUNT*pxr_pkg::PORT_W-1:0] port_in,
    output logic      [pxr_pkg::PORT_COUNT*pxr_pkg::PORT_W-1:0] port_out,
    output logic      [pxr_pkg::PORT_COUNT*pxr_pkg::PORT_W-1:0] port_oe_n,
    // status
    output logic                                   expander_enabled
);
    import pxr_pkg::*;

    localparam int PINS_W = PORT_COUNT * PORT_W;
    localparam int SYNC_W = 3 + ADDR_W + BUS_W + 1 + BUS_W + 3 + PINS_W;

    logic [SYNC_W-1:0]  raw_bundle;
    logic [SYNC_W-1:0]  sync_bundle;
    logic               sel_n_s;
    logic               ds_n_s;
    logic               rw_s;
    logic [ADDR_W-1:0]  addr_s;
    logic [BUS_W-1:0]   data_s;
    logic               breset_n_s;
    logic [BUS_W-1:0]   cfg_s;
    logic               goe_s;
    logic               abg_oe_s;
    logic               h_oe_s;
    logic [PINS_W-1:0]  pins_s;

    pxr_state_t         state;
    pxr_state_t         next_state;
    logic               cycle_is_read;
    logic               wr_en;
    logic [ADDR_W-1:0]  reg_index;
    logic [PORT_W-1:0]  bank_rd;
    logic [PINS_W-1:0]  port_data;
    logic [PINS_W-1:0]  port_dir;
    logic               in_reset;
    logic               enabled;
    logic [BUS_W-1:0]   cfg_low_drive;
    logic [PORT_COUNT-1:0] group_en;
    logic [1:0]         sync_primed;

    // every outside level passes two flops before use
    assign raw_bundle = {periph_select_n, data_strobe_n, read_write, addr, data_in,
                         board_reset_n, reset_config_input, global_output_enable,
                         group_abg_output_enable, group_h_output_enable, port_in};

    pxr_sync #(
        .W (SYNC_W)
    ) u_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (raw_bundle),
        .sync_out (sync_bundle)
    );

    assign {sel_n_s, ds_n_s, rw_s, addr_s, data_s, breset_n_s, cfg_s,
            goe_s, abg_oe_s, h_oe_s, pins_s} = sync_bundle;

    // board reset is active low; synchroniser reset value of zero reads as in reset,
    // which keeps the pins released-to-inputs until the board level is known
    assign in_reset = !breset_n_s;

    // synced straps read zero until both flops hold real pins; without this wait
    // fifteen data lines would be pulled low right after srst whatever the straps say
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_primed <= 2'b00;
        end else begin
            sync_primed <= {sync_primed[0], 1'b1};
        end
    end

    // enable forced on while board reset is held, jumper level after
    assign enabled = goe_s || in_reset;
    assign expander_enabled = enabled;

    // bus cycle engine: one access per data strobe, no relocation of select
    always_comb begin
        next_state = state;
        case (state)
            PXR_IDLE: begin
                if (!in_reset && !sel_n_s && !ds_n_s) begin
                    next_state = rw_s ? PXR_READ : PXR_WRITE;
                end
            end
            PXR_READ: begin
                next_state = PXR_HOLD;
            end
            PXR_WRITE: begin
                next_state = PXR_HOLD;
            end
            PXR_HOLD: begin
                if (sel_n_s || ds_n_s) begin
                    next_state = PXR_IDLE;
                end
            end
            default: begin
                next_state = PXR_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= PXR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // remember cycle direction and freeze the register index for the cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cycle_is_read <= 1'b0;
            reg_index     <= '0;
        end else if (state == PXR_IDLE && next_state != PXR_IDLE) begin
            cycle_is_read <= rw_s;
            reg_index     <= addr_s;
        end
    end

    // write strobe fires regardless of enable; registers still take it
    assign wr_en = (state == PXR_WRITE);

    pxr_port_bank #(
        .PORTS (PORT_COUNT)
    ) u_bank (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .dir_clear (in_reset),
        .wr_en     (wr_en),
        .reg_index (reg_index),
        .wr_data   (data_s[PORT_W-1:0]),
        .rd_data   (bank_rd),
        .pins_in   (pins_s),
        .port_data (port_data),
        .port_dir  (port_dir)
    );

    // reset pattern: group 1 and group 2 both driven by the expander
    // line 8 is released when input 10 is low so the pull-up holds it high; driving
    // it high would fight any other driver on the bus
    always_comb begin
        cfg_low_drive = ~cfg_s & (CFG_GROUP1_MASK | CFG_GROUP2_MASK);
        if (!cfg_s[CFG_INHIBIT_BIT]) begin
            cfg_low_drive[CFG_INHIBITED_BIT] = 1'b0;
        end
    end

    // data bus drivers; oe_n low means driving
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_out  <= '0;
            data_oe_n <= '1;
        end else if (in_reset && sync_primed[1]) begin
            data_out  <= '0;               // only lows are driven
            data_oe_n <= ~cfg_low_drive;
        end else if (state == PXR_HOLD && cycle_is_read && enabled && !sel_n_s && !ds_n_s) begin
            data_out  <= {{(BUS_W-PORT_W){1'b0}}, bank_rd};
            data_oe_n <= '0;
        end else begin
            // disabled reads complete internally but never reach the pins
            data_out  <= '0;
            data_oe_n <= '1;
        end
    end

    // per-port group enable: e has only the global enable
    always_comb begin
        group_en         = '1;
        group_en[PORT_A] = abg_oe_s;
        group_en[PORT_B] = abg_oe_s;
        group_en[PORT_G] = abg_oe_s;
        group_en[PORT_H] = h_oe_s;
    end

    // port pin drivers: output only where direction set and all enables high
    genvar p;
    generate
        for (p = 0; p < PORT_COUNT; p++) begin : g_pins
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    port_out[p*PORT_W +: PORT_W]  <= DATA_RESET;
                    port_oe_n[p*PORT_W +: PORT_W] <= '1;
                end else begin
                    port_out[p*PORT_W +: PORT_W]  <= port_data[p*PORT_W +: PORT_W];
                    // latched values appear once enabled again
                    port_oe_n[p*PORT_W +: PORT_W] <= ~(port_dir[p*PORT_W +: PORT_W]
                                                     & {PORT_W{enabled && group_en[p]}});
                end
            end
        end
    endgenerate
endmodule

/* File: hw/pxr_pkg.sv */
// constants shared by the port expander and its helper modules
// assumes a 16-bit host bus whose low address bits pick one byte-wide register
package pxr_pkg;
    localparam int PORT_COUNT = 5;                 // ports a, b, e, g, h
    localparam int PORT_W     = 8;
    localparam int BUS_W      = 16;
    localparam int ADDR_W     = 4;
    localparam int SYNC_DEPTH = 2;
    // port numbers as they appear in the register index
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_E = 3'h2;
    localparam logic [2:0] PORT_G = 3'h3;
    localparam logic [2:0] PORT_H = 3'h4;
    // register index: addr[3:1] = port, addr[0] = 1 for direction
    localparam int REG_DIR_BIT  = 0;
    localparam int REG_PORT_LSB = 1;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET  = 8'h00;  // all pins inputs
    // reset configuration lines
    localparam logic [15:0] CFG_GROUP1_MASK = 16'hFF07;  // lines 0-2, 8-15
    localparam logic [15:0] CFG_GROUP2_MASK = 16'h00F8;  // lines 3-7
    localparam int CFG_INHIBIT_BIT  = 10;
    localparam int CFG_INHIBITED_BIT = 8;
    typedef enum logic [1:0] {
        PXR_IDLE  = 2'b00,
        PXR_READ  = 2'b01,
        PXR_WRITE = 2'b10,
        PXR_HOLD  = 2'b11
    } pxr_state_t;
endpackage

/* File: hw/pxr_sync.sv */
// two-flop synchroniser for a bundle of pin levels
// assumes multi-bit groups are stable while sampled (bus fields under strobe)
module pxr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         srst,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* File: hw/pxr_port_bank.sv */
// data and direction registers of the replaced ports, with registered read
// assumes one write strobe per bus cycle from the bus engine, same clock
module pxr_port_bank
    import pxr_pkg::*;
#(
    parameter int PORTS = PORT_COUNT
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire logic                     dir_clear,
    // register access
    input  wire logic                     wr_en,
    input  wire logic [ADDR_W-1:0]        reg_index,
    input  wire logic [PORT_W-1:0]        wr_data,
    output logic      [PORT_W-1:0]        rd_data,
    // pin levels and register contents
    input  wire logic [PORTS*PORT_W-1:0]  pins_in,
    output logic      [PORTS*PORT_W-1:0]  port_data,
    output logic      [PORTS*PORT_W-1:0]  port_dir
);
    import pxr_pkg::*;
    logic [2:0] sel_port;
    logic       sel_dir;
    logic [PORT_W-1:0] rd_view [PORTS];

    assign sel_port = reg_index[REG_PORT_LSB +: 3];
    assign sel_dir  = reg_index[REG_DIR_BIT];

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            // writes land even while outputs are disabled
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    port_data[p*PORT_W +: PORT_W] <= DATA_RESET;
                end else if (wr_en && !sel_dir && sel_port == 3'(p)) begin
                    port_data[p*PORT_W +: PORT_W] <= wr_data;
                end
            end
            // board reset returns every pin to input
            always_ff @(posedge sys_clk) begin
                if (srst || dir_clear) begin
                    port_dir[p*PORT_W +: PORT_W] <= DIR_RESET;
                end else if (wr_en && sel_dir && sel_port == 3'(p)) begin
                    port_dir[p*PORT_W +: PORT_W] <= wr_data;
                end
            end
            // outputs read back the latch, inputs read the pin
            assign rd_view[p] = (port_dir[p*PORT_W +: PORT_W] & port_data[p*PORT_W +: PORT_W])
                              | (~port_dir[p*PORT_W +: PORT_W] & pins_in[p*PORT_W +: PORT_W]);
        end
    endgenerate

    // registered read; unmapped indices read zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data <= '0;
        end else if (int'(sel_port) >= PORTS) begin
            rd_data <= '0;
        end else if (sel_dir) begin
            rd_data <= port_dir[sel_port*PORT_W +: PORT_W];
        end else begin
            rd_data <= rd_view[sel_port];
        end
    end
endmodule

/* File: bench/pxr_chk.sv */
// timing checks on the port expander's data bus and pin enables
// assumes sys_clk domain only; inputs reach the core after two sync flops
module pxr_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        srst,
    // host bus
    input wire logic        periph_select_n,
    input wire logic        data_strobe_n,
    input wire logic        read_write,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe_n,
    // board side
    input wire logic        board_reset_n,
    input wire logic [15:0] reset_config_input,
    input wire logic        global_output_enable,
    input wire logic        group_abg_output_enable,
    input wire logic        group_h_output_enable,
    input wire logic [39:0] port_oe_n,
    input wire logic        expander_enabled
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // repetition counts cover two sync flops plus the output register
    a_disabled_quiet: assert property ((!global_output_enable && board_reset_n)[*5] |-> &data_oe_n && &port_oe_n)
        else $error("outputs driven while disabled");
    a_forced_enable: assert property ((!board_reset_n)[*3] |-> expander_enabled)
        else $error("not enabled during board reset");
    a_enable_reverts: assert property ((board_reset_n && !global_output_enable)[*3] |-> !expander_enabled)
        else $error("enable did not revert");
    a_reset_pattern: assert property ((!board_reset_n && $stable(reset_config_input))[*5]
        |-> (data_oe_n | 16'h0100) == (reset_config_input | 16'h0100) && data_out == 16'h0000)
        else $error("reset pattern wrong");
    a_line8_high: assert property ((!board_reset_n && !reset_config_input[10])[*5] |-> data_oe_n[8])
        else $error("line 8 driven while inhibited");
    a_reset_inputs: assert property ((!board_reset_n)[*5] |-> &port_oe_n)
        else $error("pins driven in board reset");
    a_group_abg_off: assert property ((!group_abg_output_enable)[*5] |-> &port_oe_n[15:0] && &port_oe_n[31:24])
        else $error("group abg still driven");
    a_group_h_off: assert property ((!group_h_output_enable)[*5] |-> &port_oe_n[39:32])
        else $error("port h still driven");
    a_read_drive: assert property ((!periph_select_n && !data_strobe_n && read_write && global_output_enable
        && board_reset_n)[*7] |-> data_oe_n == 16'h0000)
        else $error("read data not driven");
    a_idle_release: assert property ((data_strobe_n && board_reset_n)[*6] |-> &data_oe_n)
        else $error("bus driven with strobe idle");
endmodule

bind pxr_port_expander pxr_chk u_chk (.sys_clk(sys_clk), .srst(srst), .periph_select_n(periph_select_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .data_out(data_out), .data_oe_n(data_oe_n),
    .board_reset_n(board_reset_n), .reset_config_input(reset_config_input),
    .global_output_enable(global_output_enable), .group_abg_output_enable(group_abg_output_enable),
    .group_h_output_enable(group_h_output_enable), .port_oe_n(port_oe_n), .expander_enabled(expander_enabled));

/* File: bench/pxr_host_model.sv */
// host bus master: one register access per strobe low, fast termination
// assumes data bus pull-ups; drives 1 ns after the clock edge
module pxr_host_model (
    // clock and board reset
    input  wire logic                        sys_clk,
    input  wire logic                        board_reset_n,
    // bus towards the expander
    output logic                             periph_select_n,
    output logic                             data_strobe_n,
    output logic                             read_write,
    output logic [pxr_pkg::ADDR_W-1:0]       addr,
    output logic [pxr_pkg::BUS_W-1:0]        data_in,
    input  wire logic [pxr_pkg::BUS_W-1:0]   data_out,
    input  wire logic [pxr_pkg::BUS_W-1:0]   data_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    import pxr_pkg::*;
    logic [15:0] mode_latch;
    initial begin
        {periph_select_n, data_strobe_n, read_write, addr, data_in} = {3'b111, 4'h0, 16'h0000};
    end
    // mode taken from bus levels, released lines read high by pull-up
    always @(posedge board_reset_n) begin
        mode_latch <= data_oe_n | data_out;
    end
    // 16-bit access held until the sample, no acknowledge to wait
    task automatic access(input logic rd, input logic [3:0] idx, input logic [15:0] wd,
                          output logic [15:0] rdat, output logic [15:0] roe);
        @(posedge sys_clk);
        #1;
        {periph_select_n, data_strobe_n, read_write, addr, data_in} = {2'b00, rd, idx, wd};
        repeat (8) @(posedge sys_clk);
        #1;
        rdat = data_out | data_oe_n;  // released lines float up to the pull-ups
        roe  = data_oe_n;
        {periph_select_n, data_strobe_n} = 2'b11;
        addr    = ~idx;  // released lines must not keep their value
        data_in = ~wd;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the port expander
// assumes the host model ends each access itself; inputs change 1 ns after edges
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pxr_pkg::*;
    logic        sys_clk, srst, board_reset_n, global_output_enable;
    logic        group_abg_output_enable, group_h_output_enable;
    logic        periph_select_n, data_strobe_n, read_write;
    logic [3:0]  addr;
    logic [15:0] data_in, data_out, data_oe_n, reset_config_input, d, o;
    logic [39:0] port_in, port_out, port_oe_n;
    logic        expander_enabled;
    int          mismatches = 0;
    int          tests_run  = 0;
    pxr_port_expander dut (.sys_clk(sys_clk), .srst(srst), .periph_select_n(periph_select_n),
        .data_strobe_n(data_strobe_n), .read_write(read_write), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .board_reset_n(board_reset_n),
        .reset_config_input(reset_config_input), .global_output_enable(global_output_enable),
        .group_abg_output_enable(group_abg_output_enable), .group_h_output_enable(group_h_output_enable),
        .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n), .expander_enabled(expander_enabled));
    pxr_host_model host (.sys_clk(sys_clk), .board_reset_n(board_reset_n), .periph_select_n(periph_select_n),
        .data_strobe_n(data_strobe_n), .read_write(read_write), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n));
    // clock generator
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // every port to outputs; upper byte of write data must be dropped
    task automatic t_ports();
        host.access(1'b1, 4'h0, 16'h0000, d, o);
        chk(d, 16'h0096);
        chk(o, 16'h0000);
        for (int p = 0; p < PORT_COUNT; p++) begin
            host.access(1'b0, 4'(2 * p + 1), 16'h00FF, d, o);
            host.access(1'b0, 4'(2 * p), 16'(16'h5AA0 + p), d, o);
            host.access(1'b1, 4'(2 * p), 16'h0000, d, o);
            chk(d, 16'(16'h00A0 + p));
        end
        host.access(1'b1, 4'hA, 16'h0000, d, o);
        chk(d, 16'h0000);
        chk(port_oe_n, 40'h0);
        chk(port_out, 40'hA4A3A2A1A0);
        $display("t_ports done");
    endtask
    // group enables gate only their own ports
    task automatic t_groups();
        {group_abg_output_enable, group_h_output_enable} = 2'b01;
        step(5);
        chk(port_oe_n, 40'h00FF00FFFF);
        {group_abg_output_enable, group_h_output_enable} = 2'b10;
        step(5);
        chk(port_oe_n, 40'hFF00000000);
        {group_abg_output_enable, group_h_output_enable} = 2'b11;
        $display("t_groups done");
    endtask
    // disabled: writes land, reads stay off the bus
    task automatic t_disabled();
        global_output_enable = 1'b0;
        step(5);
        chk(port_oe_n, {40{1'b1}});
        chk(expander_enabled, 1'b0);
        host.access(1'b0, 4'h8, 16'h003C, d, o);
        host.access(1'b1, 4'h8, 16'h0000, d, o);
        chk(o, 16'hFFFF);
        chk(d, 16'hFFFF);
        global_output_enable = 1'b1;
        step(5);
        chk(port_out[39:32], 8'h3C);
        chk(port_oe_n[39:32], 8'h00);
        $display("t_disabled done");
    endtask
    // strobe without the select: no drive, no write
    task automatic t_unselected();
        host.read_write = 1'b0;
        host.addr = 4'h8;
        host.data_in = 16'h00C5;
        host.data_strobe_n = 1'b0;
        step(8);
        chk(data_oe_n, 16'hFFFF);
        host.data_strobe_n = 1'b1;
        step(5);
        host.access(1'b1, 4'h8, 16'h0000, d, o);
        chk(d, 16'h003C);
        $display("t_unselected done");
    endtask
    // board reset with the expander jumpered off; last pattern is the all-high one
    task automatic t_reset_pattern();
        logic [15:0] pat [4];
        logic [15:0] exp;
        pat = '{16'h5A3C, 16'hA5C3, 16'hFEFF, 16'hFFFF};
        global_output_enable = 1'b0;
        foreach (pat[i]) begin
            reset_config_input = pat[i];
            board_reset_n = 1'b0;
            step(6);
            exp = pat[i] | (pat[i][10] ? 16'h0000 : 16'h0100);
            chk(data_oe_n, exp);
            chk(data_out, 16'h0000);
            chk(expander_enabled, 1'b1);
            chk(port_oe_n, {40{1'b1}});
            board_reset_n = 1'b1;
            step(6);
            chk(host.mode_latch, exp);
            chk(expander_enabled, 1'b0);
        end
        global_output_enable = 1'b1;
        step(5);
        chk(port_oe_n, {40{1'b1}});
        $display("t_reset_pattern done");
    endtask
    task automatic stop_test();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, about twenty-seven times the expected run
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        {srst, board_reset_n, global_output_enable} = 3'b111;
        {group_abg_output_enable, group_h_output_enable} = 2'b11;
        reset_config_input = 16'hFFFF;
        port_in = 40'h0000000096;
        step(3);
        srst = 1'b0;
        step(4);
        t_ports();
        t_groups();
        t_disabled();
        t_unselected();
        t_reset_pattern();
        stop_test();
    end
endmodule
